// File: design/rbmc_pkg.sv
// Package: register map, field layout and state codes for the region and manual command bank
// Behaviour
// - Regions 3..7 each keep lower and upper bounds, split bits 31..0 and 43..32.
// - Region bound registers are readable and writable in every controller state.
// - Read-only channel state word reads 0x00000003 after reset.
// - Channel state word is readable always; software writes never change it.
// - Manual command address is readable; writable only in configuration, halted or ready.
// - Writing the command trigger launches a manual command toward memory.
// - Command trigger is write-only, writable only in configuration, halted or ready.
// - Replay policy decides the reaction to memory errors during manual commands.
package rbmc_pkg;

  localparam int unsigned NUM_BOUNDS = 20;

  // Bound registers: region 3..7, order lower_low, lower_high, upper_low, upper_high
  localparam logic [11:0] BOUND_OFFSET [0:NUM_BOUNDS-1] = '{
    12'h0b0, 12'h0b4, 12'h008, 12'h0bc,
    12'h0c0, 12'h0c4, 12'h0c8, 12'h0cc,
    12'h0d0, 12'h0d4, 12'h0d8, 12'h0dc,
    12'h0e0, 12'h0e4, 12'h0e8, 12'h0ec,
    12'h0f0, 12'h0f4, 12'h0f8, 12'h0fc
  };
  localparam logic [31:0] BOUND_RESET = 32'h0000_0000;
  localparam int unsigned HIGH_BITS = 12;

  localparam logic [11:0] CHAN_STATE_OFFSET = 12'h100;
  localparam logic [11:0] CMD_TARGET_OFFSET = 12'h108;
  localparam logic [11:0] CMD_TRIGGER_OFFSET = 12'h10c;
  localparam logic [11:0] REPLAY_OFFSET = 12'h110;

  localparam logic [31:0] CHAN_STATE_RESET = 32'h0000_0003;
  localparam logic [31:0] CMD_TARGET_RESET = 32'h0000_0000;
  localparam logic [31:0] REPLAY_RESET = 32'h0000_0002;

  // Replay policy encoding: zero abandons the command, any other value replays it
  localparam logic [31:0] REPLAY_ABORT = 32'h0000_0000;

  // Controller operating state codes
  localparam logic [2:0] ST_CONFIG = 3'h0;
  localparam logic [2:0] ST_LOW_POWER = 3'h1;
  localparam logic [2:0] ST_HALTED = 3'h2;
  localparam logic [2:0] ST_READY = 3'h3;
  localparam logic [2:0] ST_ACTIVE = 3'h4;

endpackage : rbmc_pkg

// File: design/rbmc_regs.sv
// Module: Wishbone register bank for region bounds and manual memory commands
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ns
module rbmc_regs
  import rbmc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Controller status
  input wire logic [2:0] op_state_i,
  input wire logic [31:0] chan_state_i,
  // Manual command engine
  input wire logic cmd_done_i,
  input wire logic cmd_err_i,
  output logic cmd_launch_o,
  output logic [31:0] cmd_word_o,
  output logic [31:0] cmd_target_o,
  output logic cmd_busy_o,
  output logic cmd_replay_o,
  output logic cmd_abort_o,
  output logic [31:0] replay_policy_o,
  // Region bounds, 44 bits each, index = 4*(region-3) + {upper, high}
  output logic [NUM_BOUNDS*32-1:0] bounds_o
);

  ////////////////////////////////////////////////////////////////////////////////

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  function automatic logic hit_bound(input logic [11:0] adr, input int unsigned idx);
    return adr == BOUND_OFFSET[idx];
  endfunction : hit_bound

  ////////////////////////////////////////////////////////////////////////////////

  logic [31:0] bound_q [0:NUM_BOUNDS-1];
  logic [31:0] chan_state;
  logic [31:0] cmd_target;
  logic [31:0] replay_policy;
  logic busy;

  wire logic req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic wr = req & wb_we_i;
  wire logic gate_ok = (op_state_i == ST_CONFIG) | (op_state_i == ST_HALTED) |
                       (op_state_i == ST_READY);
  wire logic hit_target = wb_adr_i == CMD_TARGET_OFFSET;
  wire logic hit_trigger = wb_adr_i == CMD_TRIGGER_OFFSET;
  wire logic hit_chan = wb_adr_i == CHAN_STATE_OFFSET;
  wire logic hit_replay = wb_adr_i == REPLAY_OFFSET;
  wire logic wr_target = wr & hit_target & gate_ok;
  wire logic wr_trigger = wr & hit_trigger & gate_ok;
  wire logic wr_replay = wr & hit_replay;
  wire logic err_in_cmd = busy & cmd_err_i;
  wire logic [31:0] trigger_word = merge_bytes(32'h0000_0000, wb_dat_i, wb_sel_i);

  logic [31:0] next_rdata;
  logic [NUM_BOUNDS-1:0] bound_hit;

  ////////////////////////////////////////////////////////////////////////////////

  // Read mux; trigger reads as zero, unmapped reads zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    for (int i = 0; i < NUM_BOUNDS; i++) begin
      if (bound_hit[i]) begin
        next_rdata = bound_q[i];
      end
    end
    if (hit_chan) begin
      next_rdata = chan_state;
    end
    if (hit_target) begin
      next_rdata = cmd_target;
    end
    if (hit_replay) begin
      next_rdata = replay_policy;
    end
  end

  // Bus acknowledge one cycle after request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= req;
      wb_dat_o <= (req & ~wb_we_i) ? next_rdata : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Region bound registers, writable in every state
  for (genvar g = 0; g < NUM_BOUNDS; g++) begin : g_bound
    localparam bit IS_HIGH = (g % 2) == 1;
    wire logic [31:0] merged = merge_bytes(bound_q[g], wb_dat_i, wb_sel_i);
    assign bound_hit[g] = hit_bound(wb_adr_i, g);
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        bound_q[g] <= BOUND_RESET;
      end else if (ce_i && wr && bound_hit[g]) begin
        bound_q[g] <= IS_HIGH ? {{(32-HIGH_BITS){1'b0}}, merged[HIGH_BITS-1:0]} : merged;
      end
    end
    assign bounds_o[g*32 +: 32] = bound_q[g];
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Channel state word follows the controller, never software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_state <= CHAN_STATE_RESET;
    end else if (ce_i) begin
      chan_state <= chan_state_i;
    end
  end

  // Command address and replay policy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_target <= CMD_TARGET_RESET;
      replay_policy <= REPLAY_RESET;
    end else if (ce_i) begin
      if (wr_target) begin
        cmd_target <= merge_bytes(cmd_target, wb_dat_i, wb_sel_i);
      end
      if (wr_replay) begin
        replay_policy <= merge_bytes(replay_policy, wb_dat_i, wb_sel_i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Manual command launch and error reaction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_launch_o <= 1'b0;
      cmd_word_o <= 32'h0000_0000;
      busy <= 1'b0;
      cmd_replay_o <= 1'b0;
      cmd_abort_o <= 1'b0;
    end else if (ce_i) begin
      cmd_launch_o <= wr_trigger;
      if (wr_trigger) begin
        cmd_word_o <= trigger_word;
      end
      cmd_replay_o <= err_in_cmd & (replay_policy != REPLAY_ABORT);
      cmd_abort_o <= err_in_cmd & (replay_policy == REPLAY_ABORT);
      if (wr_trigger) begin
        busy <= 1'b1;
      end else if (cmd_done_i || (err_in_cmd && replay_policy == REPLAY_ABORT)) begin
        busy <= 1'b0;
      end
    end
  end

  assign cmd_busy_o = busy;
  assign cmd_target_o = cmd_target;
  assign replay_policy_o = replay_policy;

endmodule : rbmc_regs

// File: tb/rbmc_regs_properties.sv
// Checker: port properties of the register bank
`timescale 1ns/1ns
module rbmc_regs_chk
  import rbmc_pkg::*;
(
  // Watched ports
  input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic cmd_launch_o, cmd_err_i, cmd_abort_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic [2:0] op_state_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i, cmd_target_o, replay_policy_o,
  input wire logic [NUM_BOUNDS*32-1:0] bounds_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire wr = wb_cyc_i & wb_stb_i & !wb_ack_o & wb_we_i & (wb_sel_i == 4'hf);
  wire ok = op_state_i inside {ST_CONFIG, ST_HALTED, ST_READY};
  wire wr_trg = wr & (wb_adr_i == CMD_TRIGGER_OFFSET);
  wire wr_tgt = wr & (wb_adr_i == CMD_TARGET_OFFSET);
  chk_trig_launch: assert property (wr_trg && ok |=> cmd_launch_o)
    else $error("launch missing");
  chk_trig_gated: assert property (wr_trg && !ok |=> !cmd_launch_o)
    else $error("launch outside state");
  chk_target_write: assert property (wr_tgt && ok |=> cmd_target_o == $past(wb_dat_i))
    else $error("target not written");
  chk_target_hold: assert property (wr_tgt && !ok |=> $stable(cmd_target_o))
    else $error("target changed");
  chk_policy_write: assert property (wr && wb_adr_i == REPLAY_OFFSET
    |=> replay_policy_o == $past(wb_dat_i))
    else $error("policy not written");
  chk_abort_cause: assert property (cmd_abort_o
    |-> $past(cmd_err_i && replay_policy_o == REPLAY_ABORT))
    else $error("abort without cause");
  chk_bound_low: assert property (wr && wb_adr_i == BOUND_OFFSET[0]
    |=> bounds_o[31:0] == $past(wb_dat_i))
    else $error("bound low not written");
  chk_bound_high: assert property (wr && wb_adr_i == BOUND_OFFSET[1]
    |=> bounds_o[63:32] == {20'h0, $past(wb_dat_i[11:0])})
    else $error("bound high wrong");
endmodule : rbmc_regs_chk
bind rbmc_regs rbmc_regs_chk chk_u (.*);

// File: tb/rbmc_regs_bench.sv
// Bench: register bank tests over Wishbone
`timescale 1ns/1ns
module rbmc_regs_bench;
  import rbmc_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, err = 0, launched, ack, launch, abort, replay;
  logic [2:0] st = ST_CONFIG;
  logic [11:0] adr = 12'h0;
  logic done = 0, busy;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0, rdat, exp, dat_o, chan = 32'h3, v, word;
  int error_cnt = 0, total_checks = 0, cyc_cnt = 0, n_abort = 0, n_replay = 0;
  rbmc_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .op_state_i(st), .chan_state_i(chan), .cmd_done_i(done), .cmd_err_i(err),
    .cmd_launch_o(launch), .cmd_word_o(word), .cmd_target_o(), .cmd_busy_o(busy),
    .cmd_replay_o(replay),
    .cmd_abort_o(abort), .replay_policy_o(), .bounds_o());
  initial forever #5 clk_i = ~clk_i;
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  always @(posedge clk_i) begin
    cyc_cnt++;
    n_abort += (abort === 1'b1);
    n_replay += (replay === 1'b1);
    if (cyc_cnt == 5000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    launched = launch;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic check(input logic [31:0] got, input logic [31:0] e);
    total_checks++;
    if (got !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, e);
    end
  endtask : check
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(0, CHAN_STATE_OFFSET, 0);
    check(rdat, 32'h3);
    bus(1, CHAN_STATE_OFFSET, 32'hffff_ffff);
    bus(0, CHAN_STATE_OFFSET, 0);
    check(rdat, 32'h3);
    chan <= 32'h5;
    @(posedge clk_i);
    bus(0, CHAN_STATE_OFFSET, 0);
    check(rdat, 32'h5);
    bus(0, REPLAY_OFFSET, 0);
    check(rdat, 32'h2);
    bus(1, 12'h004, 32'hffff_ffff);
    bus(0, 12'h004, 0);
    check(rdat, 32'h0);
    $display("status test done");
    st <= ST_ACTIVE;
    for (int g = 0; g < NUM_BOUNDS; g++) begin
      v = 32'hdead_be00 + g;
      bus(0, BOUND_OFFSET[g], 0);
      check(rdat, 32'h0);
      bus(1, BOUND_OFFSET[g], v);
      bus(0, BOUND_OFFSET[g], 0);
      check(rdat, g % 2 ? v & 32'h0000_0fff : v);
    end
    sel <= 4'h1;
    bus(1, BOUND_OFFSET[0], 32'h1122_3344);
    sel <= 4'hf;
    bus(0, BOUND_OFFSET[0], 0);
    check(rdat, 32'hdead_be44);
    bus(1, REPLAY_OFFSET, 32'h0);
    bus(0, REPLAY_OFFSET, 0);
    check(rdat, 32'h0);
    $display("bounds test done");
    exp = 32'h0;
    for (int s = 0; s < 5; s++) begin
      st <= 3'(s);
      if (s != 1 && s != 4) exp = 32'h100 + s;
      bus(1, CMD_TARGET_OFFSET, 32'h100 + s);
      bus(0, CMD_TARGET_OFFSET, 0);
      check(rdat, exp);
      bus(1, CMD_TRIGGER_OFFSET, 32'h200 + s);
      check(32'(launched), 32'(s != 1 && s != 4));
    end
    check(word, 32'h203);
    bus(0, CMD_TRIGGER_OFFSET, 0);
    check(rdat, 32'h0);
    $display("gating test done");
    err <= 1'b1;
    @(posedge clk_i);
    err <= 1'b0;
    repeat (3) @(posedge clk_i);
    check(32'(n_abort), 32'h1);
    check(32'(busy), 32'h0);
    st <= ST_READY;
    bus(1, REPLAY_OFFSET, 32'h5);
    bus(1, CMD_TRIGGER_OFFSET, 32'h1);
    err <= 1'b1;
    @(posedge clk_i);
    err <= 1'b0;
    repeat (3) @(posedge clk_i);
    check(32'(n_replay), 32'h1);
    check(32'(busy), 32'h1);
    done <= 1'b1;
    @(posedge clk_i);
    done <= 1'b0;
    @(posedge clk_i);
    check(32'(busy), 32'h0);
    $display("replay test done");
    finish_test();
  end
endmodule : rbmc_regs_bench
